// ===== testbench/mcjump_fetch_model.sv
// partner: instruction fetch and alu flag source facing the jump unit
`timescale 1ns/1ps
module mcjump_fetch_model (
    // clock
    input wire logic hclk,
    // fetch side
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic [9:0] instr_addr,
    output logic [15:0] alu_cond_flags
);
    // =========================================================
    // idle values at time zero
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        instr_addr = 10'h000;
        alu_cond_flags = 16'h0000;
    end
    // one fetched word, entered just after a rising edge
    task automatic issue(input logic [15:0] w, input logic [9:0] a, input logic [15:0] f);
        instr_valid <= 1'b1;
        instr_word <= w;
        instr_addr <= a;
        alu_cond_flags <= f;
        @(posedge hclk);
        // slot over: scramble the word so a stale value never looks valid
        instr_valid <= 1'b0;
        instr_word <= ~w;
        instr_addr <= ~a;
    endtask
endmodule

// ===== testbench/tb_microcore_conditional_jump_unit.sv
// testbench: bus and instruction sequences with expected program counters
`timescale 1ns/1ps
module tb_microcore_conditional_jump_unit;
    // =========================================================
    // stimulus and observed signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] fb = 16'h0000; // feedback pins in selector code order
    logic hreadyout, hresp, iv, jt, pu;
    logic [31:0] hrdata, rd;
    logic [15:0] iw, af;
    logic [9:0] ia, pc;
    logic [9:0] jr [2] = '{10'h3a5, 10'h05a}; // jump register contents
    logic [15:0] pat [4] = '{16'ha5c3, 16'h3c96, 16'h0ff1, 16'hf00e};
    logic [31:0] ra [4] = '{32'h404, 32'h408, 32'h484, 32'h488};
    logic t;
    logic ce = 1'b1; // clock enable, dropped once to show the freeze
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    always #25 hclk = ~hclk;
    // =========================================================
    // design and partner
    mcjump_core dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(iv),
        .instr_word(iw), .instr_addr(ia), .alu_cond_flags(af),
        .hs_vds_fbk({fb[8], fb[6], fb[4], fb[2], fb[0]}),
        .hs_src_fbk({fb[9], fb[7], fb[5], fb[3], fb[1]}), .ls_vds_fbk(fb[15:10]),
        .microcore_program_counter(pc), .jump_taken(jt), .pc_update(pu));
    mcjump_fetch_model fm_u (.hclk(hclk), .instr_valid(iv), .instr_word(iw),
        .instr_addr(ia), .alu_cond_flags(af));
    // =========================================================
    // helpers
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end
    task automatic wait_hr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        wait_hr();
        htrans <= 2'b00;
        hwdata <= d;
        wait_hr();
    endtask
    task automatic ahb_rd(input logic [31:0] a, input logic [31:0] exp);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'b10;
        wait_hr();
        htrans <= 2'b00;
        wait_hr();
        chk(hrdata, exp, "read data");
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask
    // one instruction and its outcome one edge later
    task automatic run(input logic [15:0] w, input logic [9:0] a, input logic [15:0] f,
                       input logic [9:0] epc, input logic et);
        fm_u.issue(w, a, f);
        #1;
        chk({22'h0, pc}, {22'h0, epc}, "next pc");
        chk({31'h0, jt}, {31'h0, et}, "jump taken");
        chk({31'h0, pu}, 32'h1, "pc update");
        @(posedge hclk);
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge hclk);
        chk({hreadyout, hresp, jt, pu, pc}, {4'b1000, 10'h000}, "reset outputs");
        chk(hrdata, 32'h0, "reset read data");
        hresetn <= 1'b1;
        // registers: reset value, write, read back, unmapped place
        for (int c = 0; c < 4; c++) begin
            ahb_rd(ra[c], 32'h0);
            ahb_wr(ra[c], {16'h0, pat[c]});
            ahb_rd(ra[c], {16'h0, pat[c]});
        end
        ahb_rd(32'h400, 32'h0);
        ahb_wr(32'h4c0, {22'h0, jr[0]});
        ahb_wr(32'h4c4, {22'h0, jr[1]});
        ahb_rd(32'h4c4, {22'h0, jr[1]});
        // arithmetic relative: every selector, both offset ends, wrap
        for (int s = 0; s < 16; s++) begin
            run({7'h12, s[3:0], 5'h10}, 10'h005, 16'h1 << s, 10'h3f5, 1'b1);
            run({7'h12, s[3:0], 5'h0f}, 10'h3fa, ~(16'h1 << s), 10'h3fb, 1'b0);
            run({7'h12, s[3:0], 5'h0f}, 10'h3fa, 16'h1 << s, 10'h009, 1'b1);
        end
        // control bit jumps over each control register, bit and polarity
        for (int c = 0; c < 4; c++) begin
            ahb_wr(32'h4c8, c);
            for (int s = 0; s < 16; s++) begin
                for (int p = 0; p < 2; p++) begin
                    t = (pat[c][s] == p[0]);
                    run({6'h0f, p[0], s[3:0], s[0], 4'h4}, 10'h100, 16'h0,
                        t ? jr[s[0]] : 10'h101, t);
                    run({6'h08, p[0], s[3:0], 5'h1f}, 10'h200, 16'h0,
                        t ? 10'h1ff : 10'h201, t);
                end
            end
        end
        // status shows the last outcome and ignores writes
        ahb_wr(32'h4cc, 32'h0);
        ahb_rd(32'h4cc, 32'h0001_01ff);
        // enable low: a fetched word is ignored and all state holds
        ce <= 1'b0;
        fm_u.issue(16'h0000, 10'h077, 16'h0);
        #1;
        chk({22'h0, pc}, 32'h0000_01ff, "frozen pc");
        chk({31'h0, pu}, 32'h0, "frozen update");
        @(posedge hclk);
        ce <= 1'b1;
        // feedback far jump: one live pin at a time, both polarities
        for (int s = 0; s < 16; s++) begin
            fb <= 16'h1 << s;
            repeat (3) @(posedge hclk);
            run({6'h0e, s[3:0], 1'b1, s[0], 4'h4}, 10'h040, 16'h0, jr[s[0]], 1'b1);
            run({6'h0e, s[3:0], 1'b0, s[0], 4'h4}, 10'h040, 16'h0, 10'h041, 1'b0);
        end
        close_out();
    end
endmodule

// ===== verilog/mcjump_bitpick.sv
// module: picks one bit of a vector and compares it with a polarity
`timescale 1ns/1ps
module mcjump_bitpick #(
    parameter int unsigned W = 16,
    parameter int unsigned S = 4
) (
    // selection
    input wire logic [W-1:0] vec,
    input wire logic [S-1:0] sel,
    input wire logic pol,
    // result
    output logic hit
);
    // =========================================================
    // condition true when the chosen bit equals the polarity
    always_comb begin
        hit = (vec[sel] == pol);
    end
endmodule

// ===== verilog/mcjump_core.sv
// module: conditional jump decode and program counter update with ahb-lite registers
//
// Summary of operation
// - arithmetic relative jump taken on chosen flag
// - offset is 5-bit two's complement
// - relative target from jump instruction address
// - selector codes 0..7 map first eight flags
// - selector codes 8..15 map last eight flags
// - flags come from alu condition register
// - arithmetic jump opcode and field layout
// - control bit match loads jump register
// - 4-bit selector picks control register bit
// - polarity bit chooses active level
// - control absolute jump field layout
// - control relative jump to address plus offset
// - feedback match loads jump register
// - feedback selector maps high then low side
// - feedback absolute jump field layout
// - any jump register value is valid target
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mcjump_core (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // instruction fetch and alu, same clock
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [9:0] instr_addr,
    input wire logic [15:0] alu_cond_flags,
    // pre-driver feedback pins, asynchronous
    input wire logic [4:0] hs_vds_fbk,
    input wire logic [4:0] hs_src_fbk,
    input wire logic [5:0] ls_vds_fbk,
    // program counter result
    output logic [9:0] microcore_program_counter,
    output logic jump_taken,
    output logic pc_update
);
    localparam int unsigned PW = mcjump_pkg::PC_W;
    localparam int unsigned SW = mcjump_pkg::SEL_W;
    localparam int unsigned NB = mcjump_pkg::NBIT;
    localparam int unsigned OM = mcjump_pkg::OPC_MSB;

    // =========================================================
    // state record
    typedef struct packed {
        mcjump_pkg::mcjump_bus_st_t fsm; // bus phase
        logic [9:0] wr_idx; // index of pending write
        logic [3:0][15:0] flags; // control registers a0 a1 b0 b1
        logic [1:0][PW-1:0] jreg; // jump register subset
        logic [1:0] core_sel; // which control register is used
        logic [PW-1:0] pc; // program counter
        logic taken; // last decision
        logic upd; // pc updated pulse
        logic [31:0] rdata; // read data
        logic ready; // hreadyout
        logic resp; // hresp
    } mcjump_st_t;
    mcjump_st_t st_q;
    mcjump_st_t st_d;

    // =========================================================
    // feedback pins through two flops
    logic [NB-1:0] fbk_raw; // selector-ordered feedback
    logic [NB-1:0] fbk_sync; // synchronised feedback
    always_comb begin
        fbk_raw = '0;
        for (int k = 0; k < mcjump_pkg::HS_N; k++) begin
            fbk_raw[2*k] = hs_vds_fbk[k];
            fbk_raw[2*k+1] = hs_src_fbk[k];
        end
        for (int j = 0; j < mcjump_pkg::LS_N; j++) begin
            fbk_raw[mcjump_pkg::FB_LS_BASE+j] = ls_vds_fbk[j];
        end
    end
    mcjump_sync #(.W(NB)) u_fbk_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d_async(fbk_raw),
        .d_sync(fbk_sync)
    );

    // =========================================================
    // instruction decode
    logic is_arith_rel; // arithmetic relative
    logic is_ctrl_far; // control absolute
    logic is_ctrl_rel; // control relative
    logic is_fbk_far; // feedback absolute
    logic [15:0] ctrl_word; // control register in use
    logic [PW-1:0] jreg_val; // chosen jump register
    logic [PW-1:0] rel_target; // relative target
    logic [PW-1:0] seq_pc; // next sequential address
    always_comb begin
        is_arith_rel = instr_word[OM -: mcjump_pkg::OPC7_W] == mcjump_pkg::OP_ARITH_REL;
        is_ctrl_far = (instr_word[OM -: mcjump_pkg::OPC6_W] == mcjump_pkg::OP_CTRL_FAR)
            && (instr_word[3:0] == mcjump_pkg::FAR_TAIL);
        is_ctrl_rel = instr_word[OM -: mcjump_pkg::OPC6_W] == mcjump_pkg::OP_CTRL_REL;
        is_fbk_far = (instr_word[OM -: mcjump_pkg::OPC6_W] == mcjump_pkg::OP_FBK_FAR)
            && (instr_word[3:0] == mcjump_pkg::FAR_TAIL);
        ctrl_word = st_q.flags[st_q.core_sel];
        jreg_val = st_q.jreg[instr_word[mcjump_pkg::JREG_BIT]];
        // sign-extend before the add, wrap in pc width
        rel_target = PW'(instr_addr + {{(PW-mcjump_pkg::OFS_W){instr_word[4]}},
            instr_word[4:0]});
        seq_pc = PW'(instr_addr + 10'h001);
    end

    // =========================================================
    // condition pickers
    logic alu_hit; // chosen alu flag set
    logic cr_hit; // control bit matches polarity
    logic fb_hit; // feedback matches polarity
    mcjump_bitpick #(.W(NB), .S(SW)) u_alu_pick (
        .vec(alu_cond_flags),
        .sel(instr_word[mcjump_pkg::ALU_SEL_LSB +: SW]),
        .pol(1'b1),
        .hit(alu_hit)
    );
    mcjump_bitpick #(.W(NB), .S(SW)) u_cr_pick (
        .vec(ctrl_word),
        .sel(instr_word[mcjump_pkg::CR_SEL_LSB +: SW]),
        .pol(instr_word[mcjump_pkg::CR_POL_BIT]),
        .hit(cr_hit)
    );
    mcjump_bitpick #(.W(NB), .S(SW)) u_fb_pick (
        .vec(fbk_sync),
        .sel(instr_word[mcjump_pkg::FB_SEL_LSB +: SW]),
        .pol(instr_word[mcjump_pkg::FB_POL_BIT]),
        .hit(fb_hit)
    );

    // =========================================================
    // jump decision and target
    logic take; // jump is taken
    logic [PW-1:0] next_pc; // next program counter
    always_comb begin
        take = 1'b0;
        next_pc = seq_pc;
        if (is_arith_rel && alu_hit) begin
            take = 1'b1;
            next_pc = rel_target;
        end else if (is_ctrl_far && cr_hit) begin
            take = 1'b1;
            next_pc = jreg_val;
        end else if (is_ctrl_rel && cr_hit) begin
            take = 1'b1;
            next_pc = rel_target;
        end else if (is_fbk_far && fb_hit) begin
            take = 1'b1;
            next_pc = jreg_val;
        end
    end

    // =========================================================
    // register read mux, forwards a write still in its data phase
    logic [9:0] a_idx; // word index of address phase
    logic [31:0] rd_mux; // read value
    logic [15:0] fwd; // data written this cycle
    always_comb begin
        a_idx = haddr[11:2];
        fwd = hwdata[15:0];
        rd_mux = 32'h0000_0000;
        if (a_idx == mcjump_pkg::IDX_FLAGS_A0) begin
            rd_mux[15:0] = st_q.flags[0];
        end else if (a_idx == mcjump_pkg::IDX_FLAGS_A1) begin
            rd_mux[15:0] = st_q.flags[1];
        end else if (a_idx == mcjump_pkg::IDX_FLAGS_B0) begin
            rd_mux[15:0] = st_q.flags[2];
        end else if (a_idx == mcjump_pkg::IDX_FLAGS_B1) begin
            rd_mux[15:0] = st_q.flags[3];
        end else if (a_idx == mcjump_pkg::IDX_JUMP_REG0) begin
            rd_mux[PW-1:0] = st_q.jreg[0];
        end else if (a_idx == mcjump_pkg::IDX_JUMP_REG1) begin
            rd_mux[PW-1:0] = st_q.jreg[1];
        end else if (a_idx == mcjump_pkg::IDX_CONFIG) begin
            rd_mux[1:0] = st_q.core_sel;
        end else if (a_idx == mcjump_pkg::IDX_STATUS) begin
            rd_mux[PW-1:0] = st_q.pc;
            rd_mux[mcjump_pkg::STAT_TAKEN_BIT] = st_q.taken;
        end
        // same-index write in data phase overrides stale value
        if (st_q.fsm == mcjump_pkg::BUS_WDATA && st_q.wr_idx == a_idx
            && a_idx != mcjump_pkg::IDX_STATUS) begin
            if (a_idx == mcjump_pkg::IDX_CONFIG) begin
                rd_mux[1:0] = fwd[1:0];
            end else if (a_idx == mcjump_pkg::IDX_JUMP_REG0
                || a_idx == mcjump_pkg::IDX_JUMP_REG1) begin
                rd_mux[PW-1:0] = fwd[PW-1:0];
            end else begin
                rd_mux[15:0] = fwd;
            end
        end
    end

    // =========================================================
    // next state: bus slave and program counter
    logic a_req; // valid address phase
    always_comb begin
        st_d = st_q;
        a_req = hsel && htrans[1] && hready;
        st_d.ready = 1'b1; // always zero wait states
        st_d.resp = 1'b0; // always okay
        st_d.upd = 1'b0;
        // write data phase stores the word
        case (st_q.fsm)
            mcjump_pkg::BUS_WDATA: begin
                if (st_q.wr_idx == mcjump_pkg::IDX_FLAGS_A0) begin
                    st_d.flags[0] = hwdata[15:0];
                end else if (st_q.wr_idx == mcjump_pkg::IDX_FLAGS_A1) begin
                    st_d.flags[1] = hwdata[15:0];
                end else if (st_q.wr_idx == mcjump_pkg::IDX_FLAGS_B0) begin
                    st_d.flags[2] = hwdata[15:0];
                end else if (st_q.wr_idx == mcjump_pkg::IDX_FLAGS_B1) begin
                    st_d.flags[3] = hwdata[15:0];
                end else if (st_q.wr_idx == mcjump_pkg::IDX_JUMP_REG0) begin
                    st_d.jreg[0] = hwdata[PW-1:0];
                end else if (st_q.wr_idx == mcjump_pkg::IDX_JUMP_REG1) begin
                    st_d.jreg[1] = hwdata[PW-1:0];
                end else if (st_q.wr_idx == mcjump_pkg::IDX_CONFIG) begin
                    st_d.core_sel = hwdata[1:0];
                end
            end
            default: begin
            end
        endcase
        // address phase
        st_d.fsm = mcjump_pkg::BUS_IDLE;
        if (a_req && hwrite) begin
            st_d.fsm = mcjump_pkg::BUS_WDATA;
            st_d.wr_idx = a_idx;
        end
        if (a_req && !hwrite) begin
            st_d.rdata = rd_mux;
        end
        // one instruction per valid fetch
        if (instr_valid) begin
            st_d.pc = next_pc;
            st_d.taken = take;
            st_d.upd = 1'b1;
        end
    end

    // =========================================================
    // state registers, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q.fsm <= mcjump_pkg::BUS_IDLE;
            st_q.wr_idx <= 10'h000;
            st_q.flags <= {4{mcjump_pkg::FLAGS_RST}};
            st_q.jreg <= {2{mcjump_pkg::JREG_RST}};
            st_q.core_sel <= 2'h0;
            st_q.pc <= mcjump_pkg::PC_RST;
            st_q.taken <= 1'b0;
            st_q.upd <= 1'b0;
            st_q.rdata <= 32'h0000_0000;
            st_q.ready <= 1'b1;
            st_q.resp <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // outputs
    assign hreadyout = st_q.ready;
    assign hresp = st_q.resp;
    assign hrdata = st_q.rdata;
    assign microcore_program_counter = st_q.pc;
    assign jump_taken = st_q.taken;
    assign pc_update = st_q.upd;

    // =========================================================
    // checks
    property p_arith_taken;
        @(posedge hclk) disable iff (!hresetn)
        ce && instr_valid && is_arith_rel && alu_cond_flags[instr_word[8:5]]
        |=> jump_taken && microcore_program_counter == $past(rel_target);
    endproperty
    a_arith_taken: assert property (p_arith_taken) else $error("arith jump missed");

    property p_untaken;
        @(posedge hclk) disable iff (!hresetn)
        ce && instr_valid && !take
        |=> !jump_taken && microcore_program_counter == $past(seq_pc);
    endproperty
    a_untaken: assert property (p_untaken) else $error("untaken jump wrong pc");

    property p_most_negative;
        @(posedge hclk) disable iff (!hresetn)
        ce && instr_valid && is_arith_rel && alu_hit && instr_word[4:0] == 5'h10
        |=> PW'(microcore_program_counter + 10'h010) == $past(instr_addr);
    endproperty
    a_most_negative: assert property (p_most_negative) else $error("offset -16 wrong");

    property p_ctrl_far;
        @(posedge hclk) disable iff (!hresetn)
        ce && instr_valid && is_ctrl_far
        && ctrl_word[instr_word[8:5]] == instr_word[9]
        |=> microcore_program_counter == $past(jreg_val);
    endproperty
    a_ctrl_far: assert property (p_ctrl_far) else $error("control far jump missed");

    property p_ctrl_pol;
        @(posedge hclk) disable iff (!hresetn)
        ce && instr_valid && is_ctrl_rel
        && ctrl_word[instr_word[8:5]] != instr_word[9]
        |=> !jump_taken;
    endproperty
    a_ctrl_pol: assert property (p_ctrl_pol) else $error("polarity ignored");

    property p_fbk_far;
        @(posedge hclk) disable iff (!hresetn)
        ce && instr_valid && is_fbk_far && fbk_sync[instr_word[9:6]] == instr_word[5]
        |=> jump_taken && microcore_program_counter == $past(jreg_val);
    endproperty
    a_fbk_far: assert property (p_fbk_far) else $error("feedback far jump missed");

    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        !ce |=> $stable(microcore_program_counter) && $stable(hrdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_jreg_write;
        @(posedge hclk) disable iff (!hresetn)
        ce && st_q.fsm == mcjump_pkg::BUS_WDATA && st_q.wr_idx == mcjump_pkg::IDX_JUMP_REG1
        |=> st_q.jreg[1] == $past(hwdata[PW-1:0]);
    endproperty
    a_jreg_write: assert property (p_jreg_write) else $error("jump register not written");
endmodule

// ===== verilog/mcjump_pkg.sv
// package: constants, register map and encodings of the conditional jump unit
package mcjump_pkg;
    // =========================================================
    // widths
    localparam int unsigned PC_W = 10;
    localparam int unsigned IW = 16;
    localparam int unsigned OFS_W = 5;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned NBIT = 16;
    // =========================================================
    // instruction fields
    localparam int unsigned OPC_MSB = 15;
    localparam int unsigned OPC7_W = 7;
    localparam int unsigned OPC6_W = 6;
    localparam logic [6:0] OP_ARITH_REL = 7'h12;
    localparam logic [5:0] OP_CTRL_FAR = 6'h0f;
    localparam logic [5:0] OP_CTRL_REL = 6'h08;
    localparam logic [5:0] OP_FBK_FAR = 6'h0e;
    localparam logic [3:0] FAR_TAIL = 4'h4;
    localparam int unsigned ALU_SEL_LSB = 5;
    localparam int unsigned CR_POL_BIT = 9;
    localparam int unsigned CR_SEL_LSB = 5;
    localparam int unsigned FB_SEL_LSB = 6;
    localparam int unsigned FB_POL_BIT = 5;
    localparam int unsigned JREG_BIT = 4;
    // =========================================================
    // alu condition flag positions, selector code order
    typedef enum logic [3:0] {
        ALU_OPD, ALU_OVS, ALU_UNS, ALU_OVU, ALU_UNU, ALU_SGN, ALU_ZERO, ALU_MLOSS,
        ALU_MOVER, ALU_ALL1, ALU_ALL0, ALU_A0, ALU_A1, ALU_CARRY, ALU_CONV, ALU_CSH
    } mcjump_alu_flag_t;
    // =========================================================
    // feedback vector layout
    localparam int unsigned HS_N = 5;
    localparam int unsigned LS_N = 6;
    localparam int unsigned FB_LS_BASE = 10;
    // =========================================================
    // register indices, byte address is index times four
    localparam logic [9:0] IDX_FLAGS_A0 = 10'h101;
    localparam logic [9:0] IDX_FLAGS_A1 = 10'h102;
    localparam logic [9:0] IDX_FLAGS_B0 = 10'h121;
    localparam logic [9:0] IDX_FLAGS_B1 = 10'h122;
    localparam logic [9:0] IDX_JUMP_REG0 = 10'h130;
    localparam logic [9:0] IDX_JUMP_REG1 = 10'h131;
    localparam logic [9:0] IDX_CONFIG = 10'h132;
    localparam logic [9:0] IDX_STATUS = 10'h133;
    localparam int unsigned STAT_TAKEN_BIT = 16;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [9:0] JREG_RST = 10'h000;
    localparam logic [9:0] PC_RST = 10'h000;
    // =========================================================
    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WDATA = 2'b10
    } mcjump_bus_st_t;
endpackage

// ===== verilog/mcjump_sync.sv
// module: two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module mcjump_sync #(
    parameter int unsigned W = 16
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // levels
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] d_sync
);
    typedef struct packed {
        logic [W-1:0] s1; // first stage, read only by s2
        logic [W-1:0] s2; // second stage
    } mcjump_sync_st_t;
    mcjump_sync_st_t st_q;
    mcjump_sync_st_t st_d;
    // =========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.s1 = d_async;
        st_d.s2 = st_q.s1;
    end
    // =========================================================
    // registers, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
    assign d_sync = st_q.s2;
endmodule
